/* File: inc/loop_fault_pkg.sv */
// Purpose: Shared constants and types for the loop converter serial port and fault logic
// Assumes: 200 MHz system clock; serial frames of 24 bits, MSB first
// Notes: Register offsets are 7-bit command addresses; bit 7 of the command selects a read
package loop_fault_pkg;

  // Clock and timing
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned TICK_MS = 50;
  localparam int unsigned TICK_CYCLES = TICK_MS * CLK_MHZ * 1000;
  localparam int unsigned RETRY_SETTLE_CYCLES = 16;
  localparam int unsigned STRAP_WAIT = 3;

  // Frame geometry
  localparam int unsigned FRAME_BITS = 24;
  localparam logic [4:0] FRAME_LAST = 5'h17;

  // Register offsets
  localparam logic [6:0] ADDR_NULL = 7'h00;
  localparam logic [6:0] ADDR_COMMIT = 7'h01;
  localparam logic [6:0] ADDR_NOP = 7'h02;
  localparam logic [6:0] ADDR_MODE = 7'h03;
  localparam logic [6:0] ADDR_CODE = 7'h04;
  localparam logic [6:0] ADDR_CFG = 7'h05;
  localparam logic [6:0] ADDR_ALARM_LO = 7'h06;
  localparam logic [6:0] ADDR_ALARM_HI = 7'h07;
  localparam logic [6:0] ADDR_STATUS = 7'h09;

  // Command key and reset values
  localparam logic [15:0] COMMIT_KEY = 16'h00FF;
  localparam logic [15:0] CODE_RST_LOW_BAND = 16'h2400;
  localparam logic [15:0] CODE_RST_HIGH_BAND = 16'hE800;
  localparam logic [15:0] CFG_RST = 16'h0102;
  localparam logic [15:0] ALARM_LO_RST = 16'h0300;
  localparam logic [15:0] ALARM_HI_RST = 16'hF000;

  // Status bit positions
  localparam int unsigned ST_PRESENT = 0;
  localparam int unsigned ST_STICKY = 1;
  localparam int unsigned ST_TIMEOUT = 2;
  localparam int unsigned ST_FRAME = 3;

  typedef struct packed {
    logic is_read;
    logic [6:0] addr;
    logic [15:0] data;
  } frame_s;

  typedef struct packed {
    logic [4:0] unused;
    logic [2:0] retry_time;
    logic retry_disable;
    logic timeout_loop_mask;
    logic link_timeout_mask;
    logic loop_fault_pin_disable;
    logic [2:0] timeout_sel;
    logic loop_fault_mask;
  } err_cfg_s;

  typedef enum logic [1:0] {
    LOOP_OK = 2'b00,
    LOOP_FAULT = 2'b01,
    LOOP_RETRY = 2'b10
  } loop_state_e;

  typedef enum logic [1:0] {
    DRIVE_CODE = 2'b00,
    DRIVE_ALARM_LO = 2'b01,
    DRIVE_ALARM_HI = 2'b10
  } drive_sel_e;

endpackage

/* File: src/loop_fault_spi.sv */
// Purpose: Serial control port, register file and fault reporting of a loop current converter
// Assumes: Host serial clock well below clk/4; all pins sampled through two flip-flops
// Notes: Analogue stage sees drive_value and drive_sel; loop_fault_in flags an unsustained current
// Summary of operation
// - Loop fault drives low alarm unless masked
// - Unmasked fault retries code current periodically
// - Retry disabled: recheck only on status read or code write
// - Loop fault sets present and sticky flags
// - Present flag clears on a retry that finds no fault; follows the fault when masked
// - Flag timeout without valid write in period
// - Framing-error or address-zero writes never count
// - Timeout masks gate pin and loop reporting
// - Non-multiple of 24 clocks is frame error
// - Timeout alarm band follows band select pin
// - Loop fault wins conflicting alarm currents
// - Fault pin reports loop and timeout faults
// - Sample on rising, shift on falling edge
// - Early chip select rise aborts with fault
// - Extra clocks shift through; last 24 decoded
// - Output tristated while deselected; MSB at select
// - Frame is command byte then data word
// - Writes to read-only registers are ignored
// - Read command loads register into shifter
// - Next transfer echoes command then contents
// - Protected writes wait for commit command
// - Retry spacing is field plus one times 50 ms
// - Reset timeout selection gives 100 ms
// - Unprotected writes load at select rise
// - No-operation write counts as valid traffic
`timescale 1ns/10ps
`default_nettype none

module loop_fault_spi #(
  parameter int unsigned TICK_CYCLES = loop_fault_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Serial port pins
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic sdi,
  output logic sdo_o,
  output logic sdo_oe,
  // Fault pins and loop sense
  input wire logic alarm_band_select_pin,
  input wire logic loop_fault_in,
  output logic fault_pin_n,
  // Current command to the output stage
  output logic [15:0] drive_value,
  output loop_fault_pkg::drive_sel_e drive_sel
);

  // Pin synchronisers: sclk, chip select, data, loop sense, band select
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic sclk_prev_q;
  logic csn_prev_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= 5'h03;
      sync2_q <= 5'h03;
      sclk_prev_q <= 1'b1;
      csn_prev_q <= 1'b1;
    end else begin
      sync1_q <= {alarm_band_select_pin, loop_fault_in, sdi, chip_select_n, sclk};
      sync2_q <= sync1_q;
      sclk_prev_q <= sync2_q[0];
      csn_prev_q <= sync2_q[1];
    end
  end

  logic sclk_s;
  logic csn_s;
  logic sdi_s;
  logic loop_s;
  logic band_s;
  assign sclk_s = sync2_q[0];
  assign csn_s = sync2_q[1];
  assign sdi_s = sync2_q[2];
  assign loop_s = sync2_q[3];
  assign band_s = sync2_q[4];

  logic sclk_rise;
  logic sclk_fall;
  logic csn_fall;
  logic csn_rise;
  assign sclk_rise = !csn_s && sclk_s && !sclk_prev_q;
  assign sclk_fall = !csn_s && !sclk_s && sclk_prev_q;
  assign csn_fall = !csn_s && csn_prev_q;
  assign csn_rise = csn_s && !csn_prev_q;

  // State
  logic [23:0] shift_q, shift_d;
  logic [4:0] bit_cnt_q, bit_cnt_d;
  logic got_frame_q, got_frame_d;
  logic rose_q, rose_d;
  logic sdo_q, sdo_d;
  logic sdo_oe_q, sdo_oe_d;
  logic protect_q, protect_d;
  logic [15:0] code_q, code_d;
  loop_fault_pkg::err_cfg_s cfg_q, cfg_d;
  logic [15:0] alarm_lo_q, alarm_lo_d;
  logic [15:0] alarm_hi_q, alarm_hi_d;
  logic pend_valid_q, pend_valid_d;
  logic [6:0] pend_addr_q, pend_addr_d;
  logic [15:0] pend_data_q, pend_data_d;
  logic [1:0] strap_cnt_q, strap_cnt_d;
  logic [23:0] tick_cnt_q, tick_cnt_d;
  logic [23:0] tout_tick_q, tout_tick_d;
  logic [3:0] tout_cnt_q, tout_cnt_d;
  logic timeout_q, timeout_d;
  logic frame_fault_flag_q, frame_fault_flag_d;
  logic present_loop_fault_flag_q, present_loop_fault_flag_d;
  logic sticky_loop_q, sticky_loop_d;
  loop_fault_pkg::loop_state_e loop_q, loop_d;
  logic [3:0] retry_cnt_q, retry_cnt_d;
  logic [4:0] settle_cnt_q, settle_cnt_d;
  logic fault_pin_n_q, fault_pin_n_d;
  logic [15:0] drive_value_q, drive_value_d;
  loop_fault_pkg::drive_sel_e drive_sel_q, drive_sel_d;

  // Register read view; unmapped and write-only addresses read zero
  function automatic logic [15:0] read_reg(input logic [6:0] a, input logic [15:0] status);
    logic [15:0] v;
    v = 16'h0000;
    case (a)
      loop_fault_pkg::ADDR_MODE: v = {15'h0000, protect_q};
      loop_fault_pkg::ADDR_CODE: v = code_q;
      loop_fault_pkg::ADDR_CFG: v = cfg_q;
      loop_fault_pkg::ADDR_ALARM_LO: v = alarm_lo_q;
      loop_fault_pkg::ADDR_ALARM_HI: v = alarm_hi_q;
      loop_fault_pkg::ADDR_STATUS: v = status;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  function automatic logic writable(input logic [6:0] a);
    return (a == loop_fault_pkg::ADDR_MODE) || (a == loop_fault_pkg::ADDR_CODE) ||
           (a == loop_fault_pkg::ADDR_CFG) || (a == loop_fault_pkg::ADDR_ALARM_LO) ||
           (a == loop_fault_pkg::ADDR_ALARM_HI);
  endfunction

  always_comb begin
    loop_fault_pkg::frame_s fr;
    logic [15:0] status;
    logic frame_ok;
    logic valid_write;
    logic status_read;
    logic frame_err;
    logic wr_go;
    logic [6:0] wr_addr;
    logic [15:0] wr_data;
    logic code_changed;
    logic tick;
    logic tout_tick;
    logic loop_event;
    logic loop_alarm;
    logic tout_loop;
    fr = shift_q;
    status = 16'h0000;
    status[loop_fault_pkg::ST_PRESENT] = present_loop_fault_flag_q;
    status[loop_fault_pkg::ST_STICKY] = sticky_loop_q;
    status[loop_fault_pkg::ST_TIMEOUT] = timeout_q;
    status[loop_fault_pkg::ST_FRAME] = frame_fault_flag_q;
    shift_d = shift_q;
    bit_cnt_d = bit_cnt_q;
    got_frame_d = got_frame_q;
    rose_d = rose_q;
    sdo_d = sdo_q;
    sdo_oe_d = sdo_oe_q;
    protect_d = protect_q;
    code_d = code_q;
    cfg_d = cfg_q;
    alarm_lo_d = alarm_lo_q;
    alarm_hi_d = alarm_hi_q;
    pend_valid_d = pend_valid_q;
    pend_addr_d = pend_addr_q;
    pend_data_d = pend_data_q;
    strap_cnt_d = strap_cnt_q;
    frame_ok = 1'b0;
    frame_err = 1'b0;
    valid_write = 1'b0;
    status_read = 1'b0;
    wr_go = 1'b0;
    wr_addr = loop_fault_pkg::ADDR_NULL;
    wr_data = 16'h0000;
    code_changed = 1'b0;
    tick = 1'b0;
    tout_tick = 1'b0;
    loop_event = 1'b0;
    loop_alarm = 1'b0;
    tout_loop = 1'b0;

    // Serial shifter; the host paces every bit, nothing here stalls it
    if (csn_fall) begin
      sdo_oe_d = 1'b1;
      sdo_d = shift_q[23];
      bit_cnt_d = 5'h00;
      got_frame_d = 1'b0;
      rose_d = 1'b0;
    end
    if (sclk_rise) begin
      shift_d = {shift_q[22:0], sdi_s};
      rose_d = 1'b1;
      if (bit_cnt_q == loop_fault_pkg::FRAME_LAST) begin
        bit_cnt_d = 5'h00;
        got_frame_d = 1'b1;
      end else begin
        bit_cnt_d = bit_cnt_q + 5'h01;
      end
    end
    if (sclk_fall && rose_q) begin
      sdo_d = shift_q[23];
    end
    if (csn_rise) begin
      sdo_oe_d = 1'b0;
      frame_ok = got_frame_q && (bit_cnt_q == 5'h00);
      frame_err = !frame_ok;
    end

    // Decode the last 24 bits held: command byte then data word
    if (frame_ok) begin
      if (fr.is_read) begin
        status_read = (fr.addr == loop_fault_pkg::ADDR_STATUS);
        shift_d = {fr.is_read, fr.addr, read_reg(fr.addr, status)};
      end else if (fr.addr != loop_fault_pkg::ADDR_NULL) begin
        valid_write = 1'b1;
        if (fr.addr == loop_fault_pkg::ADDR_COMMIT) begin
          if (fr.data == loop_fault_pkg::COMMIT_KEY && pend_valid_q) begin
            wr_go = 1'b1;
            wr_addr = pend_addr_q;
            wr_data = pend_data_q;
            pend_valid_d = 1'b0;
          end
        end else if (writable(fr.addr)) begin
          if (protect_q) begin
            pend_valid_d = 1'b1;
            pend_addr_d = fr.addr;
            pend_data_d = fr.data;
          end else begin
            wr_go = 1'b1;
            wr_addr = fr.addr;
            wr_data = fr.data;
          end
        end
      end
    end

    if (wr_go) begin
      case (wr_addr)
        loop_fault_pkg::ADDR_MODE: protect_d = wr_data[0];
        loop_fault_pkg::ADDR_CODE: begin
          code_d = wr_data;
          code_changed = 1'b1;
        end
        loop_fault_pkg::ADDR_CFG: cfg_d = wr_data;
        loop_fault_pkg::ADDR_ALARM_LO: alarm_lo_d = wr_data;
        loop_fault_pkg::ADDR_ALARM_HI: alarm_hi_d = wr_data;
        default: ;
      endcase
    end

    // Power-up code follows the band strap, caught once the synchroniser has settled
    if (strap_cnt_q != 2'(loop_fault_pkg::STRAP_WAIT)) begin
      strap_cnt_d = strap_cnt_q + 2'h1;
      if (strap_cnt_d == 2'(loop_fault_pkg::STRAP_WAIT) && !code_changed) begin
        code_d = band_s ? loop_fault_pkg::CODE_RST_HIGH_BAND : loop_fault_pkg::CODE_RST_LOW_BAND;
      end
    end

    // Retry timebase, restarted on fault entry so the first retry waits a full interval
    tick = (tick_cnt_q == 24'(TICK_CYCLES - 1));
    tick_cnt_d = tick ? 24'h000000 : tick_cnt_q + 24'h000001;

    // Link timeout: (selection + 1) periods of silence, own timebase restarted by traffic
    tout_tick = (tout_tick_q == 24'(TICK_CYCLES - 1));
    tout_tick_d = tout_tick ? 24'h000000 : tout_tick_q + 24'h000001;
    timeout_d = timeout_q;
    tout_cnt_d = tout_cnt_q;
    if (valid_write) begin
      timeout_d = 1'b0;
      tout_cnt_d = 4'h0;
      tout_tick_d = 24'h000000;
    end else if (tout_tick && !timeout_q) begin
      tout_cnt_d = tout_cnt_q + 4'h1;
      if (tout_cnt_d == {1'b0, cfg_q.timeout_sel} + 4'h1) begin
        timeout_d = 1'b1;
      end
    end

    // Frame flag: set wins over the clearing status read
    frame_fault_flag_d = (frame_fault_flag_q && !status_read) || frame_err;

    // Loop supervision
    loop_d = loop_q;
    retry_cnt_d = retry_cnt_q;
    settle_cnt_d = settle_cnt_q;
    present_loop_fault_flag_d = present_loop_fault_flag_q;
    loop_event = 1'b0;
    case (loop_q)
      loop_fault_pkg::LOOP_OK: begin
        present_loop_fault_flag_d = loop_s;
        loop_event = loop_s;
        if (loop_s && !cfg_q.loop_fault_mask) begin
          loop_d = loop_fault_pkg::LOOP_FAULT;
          retry_cnt_d = 4'h0;
        end
      end
      loop_fault_pkg::LOOP_FAULT: begin
        present_loop_fault_flag_d = 1'b1;
        settle_cnt_d = 5'h00;
        if (cfg_q.loop_fault_mask) begin
          loop_d = loop_fault_pkg::LOOP_OK;
        end else if (code_changed) begin
          loop_d = loop_fault_pkg::LOOP_RETRY;
        end else if (cfg_q.retry_disable) begin
          if (status_read) begin
            loop_d = loop_fault_pkg::LOOP_RETRY;
          end
        end else if (tick) begin
          retry_cnt_d = retry_cnt_q + 4'h1;
          if (retry_cnt_d == {1'b0, cfg_q.retry_time} + 4'h1) begin
            loop_d = loop_fault_pkg::LOOP_RETRY;
          end
        end
      end
      loop_fault_pkg::LOOP_RETRY: begin
        // Code current is driven for a settle window before the verdict
        settle_cnt_d = settle_cnt_q + 5'h01;
        if (settle_cnt_q == 5'(loop_fault_pkg::RETRY_SETTLE_CYCLES - 1)) begin
          retry_cnt_d = 4'h0;
          if (loop_s) begin
            loop_d = loop_fault_pkg::LOOP_FAULT;
            loop_event = 1'b1;
          end else begin
            loop_d = loop_fault_pkg::LOOP_OK;
            present_loop_fault_flag_d = 1'b0;
          end
        end
      end
      default: loop_d = loop_fault_pkg::LOOP_OK;
    endcase
    if (loop_d == loop_fault_pkg::LOOP_FAULT && loop_q != loop_fault_pkg::LOOP_FAULT) begin
      tick_cnt_d = 24'h000000;
    end
    sticky_loop_d = (sticky_loop_q && !status_read) || loop_event;

    // Current selection: loop alarm outranks timeout alarm
    loop_alarm = (loop_q == loop_fault_pkg::LOOP_FAULT) && !cfg_q.loop_fault_mask;
    tout_loop = timeout_q && !cfg_q.link_timeout_mask && !cfg_q.timeout_loop_mask;
    if (loop_alarm) begin
      drive_sel_d = loop_fault_pkg::DRIVE_ALARM_LO;
      drive_value_d = alarm_lo_q;
    end else if (tout_loop && band_s) begin
      drive_sel_d = loop_fault_pkg::DRIVE_ALARM_HI;
      drive_value_d = alarm_hi_q;
    end else if (tout_loop) begin
      drive_sel_d = loop_fault_pkg::DRIVE_ALARM_LO;
      drive_value_d = alarm_lo_q;
    end else begin
      drive_sel_d = loop_fault_pkg::DRIVE_CODE;
      drive_value_d = code_q;
    end

    fault_pin_n_d = !((present_loop_fault_flag_q && !cfg_q.loop_fault_pin_disable) ||
                      (timeout_q && !cfg_q.link_timeout_mask) ||
                      frame_fault_flag_q);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shift_q <= 24'h000000;
      bit_cnt_q <= 5'h00;
      got_frame_q <= 1'b0;
      rose_q <= 1'b0;
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
      protect_q <= 1'b0;
      code_q <= loop_fault_pkg::CODE_RST_LOW_BAND;
      cfg_q <= loop_fault_pkg::CFG_RST;
      alarm_lo_q <= loop_fault_pkg::ALARM_LO_RST;
      alarm_hi_q <= loop_fault_pkg::ALARM_HI_RST;
      pend_valid_q <= 1'b0;
      pend_addr_q <= 7'h00;
      pend_data_q <= 16'h0000;
      strap_cnt_q <= 2'h0;
      tick_cnt_q <= 24'h000000;
      tout_tick_q <= 24'h000000;
      tout_cnt_q <= 4'h0;
      timeout_q <= 1'b0;
      frame_fault_flag_q <= 1'b0;
      present_loop_fault_flag_q <= 1'b0;
      sticky_loop_q <= 1'b0;
      loop_q <= loop_fault_pkg::LOOP_OK;
      retry_cnt_q <= 4'h0;
      settle_cnt_q <= 5'h00;
      fault_pin_n_q <= 1'b1;
      drive_value_q <= loop_fault_pkg::CODE_RST_LOW_BAND;
      drive_sel_q <= loop_fault_pkg::DRIVE_CODE;
    end else begin
      shift_q <= shift_d;
      bit_cnt_q <= bit_cnt_d;
      got_frame_q <= got_frame_d;
      rose_q <= rose_d;
      sdo_q <= sdo_d;
      sdo_oe_q <= sdo_oe_d;
      protect_q <= protect_d;
      code_q <= code_d;
      cfg_q <= cfg_d;
      alarm_lo_q <= alarm_lo_d;
      alarm_hi_q <= alarm_hi_d;
      pend_valid_q <= pend_valid_d;
      pend_addr_q <= pend_addr_d;
      pend_data_q <= pend_data_d;
      strap_cnt_q <= strap_cnt_d;
      tick_cnt_q <= tick_cnt_d;
      tout_tick_q <= tout_tick_d;
      tout_cnt_q <= tout_cnt_d;
      timeout_q <= timeout_d;
      frame_fault_flag_q <= frame_fault_flag_d;
      present_loop_fault_flag_q <= present_loop_fault_flag_d;
      sticky_loop_q <= sticky_loop_d;
      loop_q <= loop_d;
      retry_cnt_q <= retry_cnt_d;
      settle_cnt_q <= settle_cnt_d;
      fault_pin_n_q <= fault_pin_n_d;
      drive_value_q <= drive_value_d;
      drive_sel_q <= drive_sel_d;
    end
  end

  assign sdo_o = sdo_q;
  assign sdo_oe = sdo_oe_q;
  assign fault_pin_n = fault_pin_n_q;
  assign drive_value = drive_value_q;
  assign drive_sel = drive_sel_q;

endmodule

`default_nettype wire

/* File: tb/loop_fault_spi_chk.sv */
// Purpose: Port-level checks for the loop converter serial port and fault pins
// Assumes: Host uses clock mode 0; bench never sets the loop masks
// Notes: Frame length is counted from the raw pins, which needs slow serial edges
`timescale 1ns/10ps
`default_nettype none
module loop_fault_spi_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Serial pins
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic sdi,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  // Fault pins and drive
  input wire logic alarm_band_select_pin,
  input wire logic loop_fault_in,
  input wire logic fault_pin_n,
  input wire logic [15:0] drive_value,
  input wire loop_fault_pkg::drive_sel_e drive_sel
);
  logic sclk_q, sclk_d, seen_q, seen_d;
  logic [4:0] cnt_q, cnt_d;
  always_comb begin
    sclk_d = sclk;
    seen_d = !chip_select_n && (seen_q || (sclk && !sclk_q));
    cnt_d = cnt_q;
    if (chip_select_n) begin
      cnt_d = 5'h00;
    end else if (sclk && !sclk_q) begin
      cnt_d = (cnt_q == loop_fault_pkg::FRAME_LAST) ? 5'h00 : cnt_q + 5'h01;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclk_q <= 1'b0;
      seen_q <= 1'b0;
      cnt_q <= 5'h00;
    end else begin
      sclk_q <= sclk_d;
      seen_q <= seen_d;
      cnt_q <= cnt_d;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence sel_held;
    !chip_select_n [*8];
  endsequence
  sequence loop_held;
    loop_fault_in [*8];
  endsequence
  // Zero clocks also counts as a bad frame
  sequence bad_end;
    $rose(chip_select_n) && (cnt_q != 5'h00 || !seen_q);
  endsequence
  AST_OE_SEL: assert property (sel_held |-> sdo_oe)
    else $error("sdo not driven while selected");
  AST_OE_IDLE: assert property (chip_select_n [*8] |-> !sdo_oe)
    else $error("sdo driven while deselected");
  AST_OE_REL: assert property ($rose(chip_select_n) |-> ##[2:7] !sdo_oe)
    else $error("sdo not released after select rise");
  AST_SDO_HOLD: assert property ((sclk && !chip_select_n) [*8] |-> $stable(sdo_o))
    else $error("sdo moved while serial clock high");
  AST_FRAME_PIN: assert property (bad_end |-> ##[1:10] !fault_pin_n)
    else $error("bad frame length not on fault pin");
  AST_LOOP_ALARM: assert property ($rose(loop_fault_in) |-> ##[2:10] drive_sel == loop_fault_pkg::DRIVE_ALARM_LO)
    else $error("loop fault did not select low alarm");
  AST_LOOP_PIN: assert property (loop_held |-> !fault_pin_n)
    else $error("loop fault not on fault pin");
  AST_LOOP_WINS: assert property (loop_held ##1 loop_fault_in [*4] |-> drive_sel != loop_fault_pkg::DRIVE_ALARM_HI)
    else $error("high alarm chosen during loop fault");
endmodule
`default_nettype wire

/* File: tb/spi_host_model.sv */
// Purpose: Serial master standing in for the host controller
// Assumes: Clock mode 0; half serial period of 8 system clocks, 80 ns period
// Notes: Data line toggles after each frame so stale bits never look valid
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  // Pacing clock
  input wire logic clk,
  // Serial pins
  output logic sclk,
  output logic chip_select_n,
  output logic sdi,
  input wire logic sdo
);
  logic [23:0] rx;
  event done;
  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    sdi = 1'b0;
    rx = 24'h000000;
  end
  // Sends tx[n-1] down to tx[0]; done fires early so a watcher never races the caller
  task automatic xfer(input logic [47:0] tx, input int n);
    @(posedge clk);
    chip_select_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi <= tx[i];
      repeat (8) @(posedge clk);
      sclk <= 1'b1;
      rx = {rx[22:0], sdo};
      repeat (8) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (8) @(posedge clk);
    chip_select_n <= 1'b1;
    sdi <= ~sdi;
    -> done;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_loop_fault_spi.sv */
// Purpose: Self-checking bench for the loop converter port and fault logic
// Assumes: TICK clocks stand for 50 ms
// Notes: Readback words are judged by a monitor from a queue of notes
`timescale 1ns/10ps
`default_nettype none
module tb_loop_fault_spi;
  localparam int unsigned TICK = 4000;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic band_pin = 1'b0;
  logic loop_fault = 1'b0;
  logic sclk, cs_n, sdi, sdo_o, sdo_oe, fault_pin_n;
  wire logic sdo_w;
  logic [15:0] drive_value, d, e;
  loop_fault_pkg::drive_sel_e drive_sel;
  logic [23:0] exp_q[$];
  int fails = 0;
  int check_count = 0;
  time t0;
  always #2.5 clk = ~clk;
  // Released line shows the inverse so a premature sample cannot pass
  assign sdo_w = sdo_oe ? sdo_o : ~sdo_o;
  loop_fault_spi #(.TICK_CYCLES(TICK)) loop_fault_spi_i (
    .clk(clk), .resetn(resetn), .sclk(sclk), .chip_select_n(cs_n), .sdi(sdi),
    .sdo_o(sdo_o), .sdo_oe(sdo_oe), .alarm_band_select_pin(band_pin),
    .loop_fault_in(loop_fault), .fault_pin_n(fault_pin_n),
    .drive_value(drive_value), .drive_sel(drive_sel));
  spi_host_model spi_host_model_i (
    .clk(clk), .sclk(sclk), .chip_select_n(cs_n), .sdi(sdi), .sdo(sdo_w));
  task automatic check(input logic [23:0] seen, input logic [23:0] want);
    check_count++;
    if (seen !== want) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] v);
    spi_host_model_i.xfer({24'h000000, 1'b0, a, v}, 24);
  endtask
  task automatic nop;
    wr(loop_fault_pkg::ADDR_NOP, 16'($urandom));
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] v);
    spi_host_model_i.xfer({24'h000000, 1'b1, a, 16'($urandom)}, 24);
    exp_q.push_back({1'b1, a, v});
    nop;
  endtask
  task automatic settle;
    repeat (8) @(posedge clk);
  endtask
  task automatic summarize;
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(spi_host_model_i.done) begin
    if (exp_q.size() > 0) begin
      check(spi_host_model_i.rx, exp_q.pop_front());
    end
  end
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    $display("watchdog expired at %0t", $time);
    summarize;
  end
  initial begin
    void'($urandom(61));
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (6) @(posedge clk);
    check(sdo_oe, 1'b0);
    check(fault_pin_n, 1'b1);
    $display("reset test done");
    rd(loop_fault_pkg::ADDR_CFG, loop_fault_pkg::CFG_RST);
    d = 16'($urandom);
    wr(loop_fault_pkg::ADDR_CODE, d);
    settle;
    check(drive_value, d);
    exp_q.push_back({1'b0, loop_fault_pkg::ADDR_CODE, d});
    nop;
    check(drive_value, d);
    d = 16'($urandom);
    e = 16'($urandom);
    spi_host_model_i.xfer({1'b0, loop_fault_pkg::ADDR_CODE, d, 1'b0, loop_fault_pkg::ADDR_CODE, e}, 48);
    settle;
    check(drive_value, e);
    check(fault_pin_n, 1'b1);
    $display("write and read test done");
    spi_host_model_i.xfer({25'h0, 1'b0, loop_fault_pkg::ADDR_CODE, d[15:1]}, 23);
    settle;
    check(fault_pin_n, 1'b0);
    check(drive_value, e);
    rd(loop_fault_pkg::ADDR_STATUS, 16'h0008);
    wr(loop_fault_pkg::ADDR_STATUS, 16'hFFFF);
    rd(loop_fault_pkg::ADDR_STATUS, 16'h0000);
    check(fault_pin_n, 1'b1);
    $display("framing test done");
    nop;
    t0 = $time;
    repeat (3) wr(loop_fault_pkg::ADDR_NULL, 16'($urandom));
    check(fault_pin_n, 1'b1);
    // Address zero traffic must not hold the timeout off; 5 ns per clock
    while (fault_pin_n === 1'b1 && $time - t0 < 15 * TICK) @(posedge clk);
    check(fault_pin_n, 1'b0);
    check($time - t0 > 10 * TICK - 80 && $time - t0 < 10 * TICK + 80, 1'b1);
    check(drive_sel, loop_fault_pkg::DRIVE_ALARM_LO);
    band_pin <= 1'b1;
    settle;
    check(drive_sel, loop_fault_pkg::DRIVE_ALARM_HI);
    loop_fault <= 1'b1;
    t0 = $time;
    repeat (12) @(posedge clk);
    check(drive_sel, loop_fault_pkg::DRIVE_ALARM_LO);
    loop_fault <= 1'b0;
    wr(loop_fault_pkg::ADDR_CFG, 16'h010E);
    for (int i = 0; i < 4 * TICK && drive_sel !== loop_fault_pkg::DRIVE_CODE; i++) @(posedge clk);
    check(drive_sel, loop_fault_pkg::DRIVE_CODE);
    check($time - t0 > 10 * TICK - 80 && $time - t0 < 10 * TICK + 80, 1'b1);
    rd(loop_fault_pkg::ADDR_STATUS, 16'h0002);
    rd(loop_fault_pkg::ADDR_STATUS, 16'h0000);
    check(fault_pin_n, 1'b1);
    $display("timeout and loop test done");
    wr(loop_fault_pkg::ADDR_CFG, 16'h018E);
    loop_fault <= 1'b1;
    repeat (12) @(posedge clk);
    check(fault_pin_n, 1'b0);
    loop_fault <= 1'b0;
    repeat (2 * TICK + 200) @(posedge clk);
    check(drive_sel, loop_fault_pkg::DRIVE_ALARM_LO);
    rd(loop_fault_pkg::ADDR_STATUS, 16'h0003);
    check(drive_sel, loop_fault_pkg::DRIVE_CODE);
    $display("retry disable test done");
    wr(loop_fault_pkg::ADDR_MODE, 16'h0001);
    d = 16'($urandom);
    wr(loop_fault_pkg::ADDR_CODE, d);
    settle;
    check(drive_value, e);
    wr(loop_fault_pkg::ADDR_COMMIT, loop_fault_pkg::COMMIT_KEY);
    settle;
    check(drive_value, d);
    $display("protected write test done");
    summarize;
  end
endmodule
bind loop_fault_spi loop_fault_spi_chk loop_fault_spi_chk_i (
  .clk(clk), .resetn(resetn), .sclk(sclk), .chip_select_n(chip_select_n), .sdi(sdi),
  .sdo_o(sdo_o), .sdo_oe(sdo_oe), .alarm_band_select_pin(alarm_band_select_pin),
  .loop_fault_in(loop_fault_in), .fault_pin_n(fault_pin_n),
  .drive_value(drive_value), .drive_sel(drive_sel));
`default_nettype wire
